// ---- pidv_ctrl.sv ----
// Top: partition-ID virtualization control and ID register logic
`timescale 1ns/1ps
module pidv_ctrl
   import pidv_pkg::*;
#(
   parameter bit HAS_EL2 = 1'b1,
   parameter bit HAS_EL3 = 1'b0,
   parameter bit HAS_VIRT = 1'b1,
   parameter bit HAS_SDEF = 1'b1,
   parameter bit HAS_FNS = 1'b1,
   parameter bit HAS_TRAP_BIT = 1'b1,
   parameter logic [7:0] MAX_MON_GROUP = 8'hFF,
   parameter logic [2:0] MAX_VPMR = 3'h0,
   parameter logic [15:0] MAX_PID = 16'hFFFF
)
(
   input wire logic mclk_i,
   input wire logic reset_n_i,
   // System instruction access
   input wire logic acc_valid_i,
   input wire logic acc_write_i,
   input wire logic [1:0] acc_op0_i,
   input wire logic [2:0] acc_op1_i,
   input wire logic [3:0] acc_crn_i,
   input wire logic [3:0] acc_crm_i,
   input wire logic [2:0] acc_op2_i,
   input wire logic [63:0] acc_wdata_i,
   // Processor state
   input wire logic [1:0] cur_el_i,
   input wire logic el2_enabled_i,
   input wire logic secure_i,
   input wire logic halted_i,
   input wire logic secure_debug_disable_i,
   input wire logic trap_general_i,
   input wire logic host_extension_i,
   input wire logic nested_virt_i,
   input wire logic nested_virt_memory_i,
   input wire logic lower_level_trap_i,
   input wire logic hyp_id_trap_bit_i,
   input wire logic secure_default_override_i,
   input wire logic force_nonsecure_i,
   // Label sources
   input wire logic [31:0] level0_label_register_i,
   input wire logic [31:0] level1_label_register_i,
   input wire logic [63:0] virtual_map_register_i,
   input wire logic [3:0] map_valid_register_i,
   // Access results
   output logic acc_done_o,
   output logic [1:0] acc_result_o,
   output logic [1:0] acc_trap_el_o,
   output logic [5:0] acc_syndrome_o,
   output logic [11:0] acc_redir_offs_o,
   output logic [63:0] acc_rdata_o,
   // Labels for level 0 and 1 requests
   output logic [15:0] instruction_partition_id_o,
   output logic [15:0] data_partition_id_o,
   output logic nonsecure_label_bit_o
);
   logic [63:0] hcr_val;
   logic id_trap_ff;
   logic gapp_lock_ff;
   logic l1_map_ff;
   logic l0_map_ff;
   logic [63:0] nxt_hcr;
   logic [63:0] id_val;
   logic hit_hcr;
   logic hit_id;
   logic [1:0] res;
   logic [1:0] tel;
   logic [63:0] rdv;
   logic use_l1;
   logic map_on;
   logic [15:0] src_i;
   logic [15:0] src_d;
   logic hcr_on;
   pidv_el_e el;
   pidv_map_if mif ();
   assign el = pidv_el_e'(cur_el_i);
   // ----------------------------------------------------------------
   // ID register value, reserved bits zero
   // ----------------------------------------------------------------
   always_comb
   begin
      id_val = '0;
      id_val[PIDV_ID_SDEF_BIT] = HAS_SDEF;
      id_val[PIDV_ID_FNS_BIT] = HAS_FNS;
      id_val[PIDV_ID_TRAP_SUP_BIT] = HAS_TRAP_BIT;
      id_val[PIDV_ID_MON_GROUP_LSB +: 8] = MAX_MON_GROUP;
      if (HAS_VIRT && HAS_EL2)
      begin
         id_val[PIDV_ID_VPMR_LSB +: 3] = MAX_VPMR;
         id_val[PIDV_ID_VIRT_BIT] = 1'b1;
      end
      id_val[15:0] = MAX_PID;
   end
   assign hcr_on = HAS_VIRT && HAS_EL2;
   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   assign hit_hcr = acc_op0_i == PIDV_OP0 && acc_op1_i == PIDV_HCR_OP1
      && acc_crn_i == PIDV_CRN && acc_crm_i == PIDV_HCR_CRM
      && acc_op2_i == PIDV_HCR_OP2;
   assign hit_id = acc_op0_i == PIDV_OP0 && acc_op1_i == PIDV_ID_OP1
      && acc_crn_i == PIDV_CRN && acc_crm_i == PIDV_ID_CRM
      && acc_op2_i == PIDV_ID_OP2 && !acc_write_i;
   // ----------------------------------------------------------------
   // Access decision
   // ----------------------------------------------------------------
   always_comb
   begin
      res = PIDV_UNDEF;
      tel = PIDV_EL0;
      rdv = '0;
      nxt_hcr = hcr_val;
      if (hit_hcr && hcr_on)
      begin
         unique case (el)
            PIDV_EL0: res = PIDV_UNDEF;
            PIDV_EL1:
            begin
               if (el2_enabled_i && nested_virt_i && nested_virt_memory_i)
                  res = PIDV_REDIR;
               else if (el2_enabled_i && nested_virt_i)
               begin
                  if (HAS_EL3 && lower_level_trap_i)
                  begin
                     res = (halted_i && secure_debug_disable_i) ? PIDV_UNDEF : PIDV_TRAP;
                     tel = PIDV_EL3;
                  end
                  else
                  begin
                     res = PIDV_TRAP;
                     tel = PIDV_EL2;
                  end
               end
            end
            PIDV_EL2:
            begin
               if (HAS_EL3 && lower_level_trap_i)
               begin
                  res = (halted_i && secure_debug_disable_i) ? PIDV_UNDEF : PIDV_TRAP;
                  tel = PIDV_EL3;
               end
               else
                  res = PIDV_OK;
            end
            PIDV_EL3: res = PIDV_OK;
         endcase
         if (res == PIDV_OK)
         begin
            rdv = hcr_val;
            if (acc_write_i)
               nxt_hcr = acc_wdata_i & PIDV_HCR_WMASK;
         end
      end
      else if (hit_id)
      begin
         unique case (el)
            PIDV_EL0: res = PIDV_UNDEF;
            PIDV_EL1, PIDV_EL2:
            begin
               if (HAS_EL3 && lower_level_trap_i)
               begin
                  res = (halted_i && secure_debug_disable_i) ? PIDV_UNDEF : PIDV_TRAP;
                  tel = PIDV_EL3;
               end
               else if (el == PIDV_EL1 && el2_enabled_i
                  && ((hcr_on && hcr_val[PIDV_HCR_ID_TRAP_BIT])
                  || (HAS_TRAP_BIT && hyp_id_trap_bit_i)))
               begin
                  res = PIDV_TRAP;
                  tel = PIDV_EL2;
               end
               else
                  res = PIDV_OK;
            end
            PIDV_EL3: res = PIDV_OK;
         endcase
         if (res == PIDV_OK)
            rdv = id_val;
      end
      // Anything else (including absent control register) is undefined
   end
   // ----------------------------------------------------------------
   // Control register state, one flop per implemented field
   // ----------------------------------------------------------------
   // Trap bit resets to 1; with level 3 present any value is legal, so one constant serves
   always_ff @(posedge mclk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         id_trap_ff <= PIDV_HCR_RST[PIDV_HCR_ID_TRAP_BIT];
      else if (acc_valid_i)
         id_trap_ff <= nxt_hcr[PIDV_HCR_ID_TRAP_BIT];
   end
   // Other fields reset free; zero keeps the first labels deterministic
   always_ff @(posedge mclk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         gapp_lock_ff <= PIDV_HCR_RST[PIDV_HCR_GAPP_LOCK_BIT];
      else if (acc_valid_i)
         gapp_lock_ff <= nxt_hcr[PIDV_HCR_GAPP_LOCK_BIT];
   end
   always_ff @(posedge mclk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         l1_map_ff <= PIDV_HCR_RST[PIDV_HCR_L1_MAP_BIT];
      else if (acc_valid_i)
         l1_map_ff <= nxt_hcr[PIDV_HCR_L1_MAP_BIT];
   end
   always_ff @(posedge mclk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         l0_map_ff <= PIDV_HCR_RST[PIDV_HCR_L0_MAP_BIT];
      else if (acc_valid_i)
         l0_map_ff <= nxt_hcr[PIDV_HCR_L0_MAP_BIT];
   end
   // Reserved bits have no storage, so they always read back as zero
   always_comb
   begin
      hcr_val = '0;
      hcr_val[PIDV_HCR_ID_TRAP_BIT] = id_trap_ff;
      hcr_val[PIDV_HCR_GAPP_LOCK_BIT] = gapp_lock_ff;
      hcr_val[PIDV_HCR_L1_MAP_BIT] = l1_map_ff;
      hcr_val[PIDV_HCR_L0_MAP_BIT] = l0_map_ff;
   end
   // ----------------------------------------------------------------
   // Access answer registers
   // ----------------------------------------------------------------
   // Done is a plain one-cycle echo of the request
   always_ff @(posedge mclk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         acc_done_o <= 1'b0;
      else
         acc_done_o <= acc_valid_i;
   end
   // Outcome holds until the next request so it may be sampled late
   always_ff @(posedge mclk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         acc_result_o <= PIDV_OK;
         acc_trap_el_o <= PIDV_EL0;
         acc_syndrome_o <= PIDV_EC_NONE;
         acc_redir_offs_o <= PIDV_REDIR_NONE;
      end
      else if (acc_valid_i)
      begin
         acc_result_o <= res;
         acc_trap_el_o <= tel;
         acc_syndrome_o <= (res == PIDV_TRAP) ? PIDV_EC_SYSREG : PIDV_EC_NONE;
         acc_redir_offs_o <= (res == PIDV_REDIR) ? PIDV_REDIR_HCR_OFFS : PIDV_REDIR_NONE;
      end
   end
   // Writes return zero so stale read data never leaks out
   always_ff @(posedge mclk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         acc_rdata_o <= '0;
      else if (acc_valid_i)
         acc_rdata_o <= acc_write_i ? '0 : rdv;
   end
   // ----------------------------------------------------------------
   // Label generation
   // ----------------------------------------------------------------
   always_comb
   begin
      use_l1 = 1'b0;
      map_on = 1'b0;
      if (el == PIDV_EL1)
         map_on = hcr_on && el2_enabled_i && hcr_val[PIDV_HCR_L1_MAP_BIT];
      else if (el == PIDV_EL0)
      begin
         use_l1 = hcr_on && el2_enabled_i && !trap_general_i
            && hcr_val[PIDV_HCR_GAPP_LOCK_BIT];
         if (use_l1)
            map_on = hcr_val[PIDV_HCR_L1_MAP_BIT];
         else
            map_on = hcr_on && el2_enabled_i && hcr_val[PIDV_HCR_L0_MAP_BIT]
               && !(host_extension_i && trap_general_i);
      end
   end
   assign src_i = (el == PIDV_EL1 || use_l1) ? level1_label_register_i[15:0]
      : level0_label_register_i[15:0];
   assign src_d = (el == PIDV_EL1 || use_l1) ? level1_label_register_i[31:16]
      : level0_label_register_i[31:16];
   assign mif.vpid_i = src_i;
   assign mif.vpid_d = src_d;
   pidv_mapper u_map (
      .map_reg_i(virtual_map_register_i),
      .map_valid_i(map_valid_register_i),
      .mif(mif)
   );
   // ----------------------------------------------------------------
   // Label output registers
   // ----------------------------------------------------------------
   always_ff @(posedge mclk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         instruction_partition_id_o <= PIDV_DEFAULT_PID;
         data_partition_id_o <= PIDV_DEFAULT_PID;
      end
      else if (secure_i && HAS_SDEF && secure_default_override_i)
      begin
         instruction_partition_id_o <= PIDV_DEFAULT_PID;
         data_partition_id_o <= PIDV_DEFAULT_PID;
      end
      else
      begin
         // Invalid mapping falls back to default ID 0
         instruction_partition_id_o <= !map_on ? src_i
            : (mif.hit_i ? mif.ppid_i : PIDV_DEFAULT_PID);
         data_partition_id_o <= !map_on ? src_d
            : (mif.hit_d ? mif.ppid_d : PIDV_DEFAULT_PID);
      end
   end
   // Reset to nonsecure so nothing leaves labelled secure before state is known
   always_ff @(posedge mclk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         nonsecure_label_bit_o <= 1'b1;
      else
         nonsecure_label_bit_o <= !secure_i || (HAS_FNS && force_nonsecure_i);
   end
endmodule

// ---- pidv_pkg.sv ----
// Package: constants for the partition-ID virtualization control block
package pidv_pkg;
   // ----------------------------------------------------------------
   // System instruction encodings
   // ----------------------------------------------------------------
   localparam logic [1:0] PIDV_OP0 = 2'h3;
   localparam logic [2:0] PIDV_HCR_OP1 = 3'h4;
   localparam logic [3:0] PIDV_CRN = 4'hA;
   localparam logic [3:0] PIDV_HCR_CRM = 4'h4;
   localparam logic [2:0] PIDV_HCR_OP2 = 3'h0;
   localparam logic [2:0] PIDV_ID_OP1 = 3'h0;
   localparam logic [3:0] PIDV_ID_CRM = 4'h4;
   localparam logic [2:0] PIDV_ID_OP2 = 3'h4;
   // ----------------------------------------------------------------
   // Control register fields
   // ----------------------------------------------------------------
   localparam int PIDV_HCR_ID_TRAP_BIT = 31;
   localparam int PIDV_HCR_GAPP_LOCK_BIT = 8;
   localparam int PIDV_HCR_L1_MAP_BIT = 1;
   localparam int PIDV_HCR_L0_MAP_BIT = 0;
   localparam logic [63:0] PIDV_HCR_WMASK = 64'h0000_0000_8000_0103;
   localparam logic [63:0] PIDV_HCR_RST = 64'h0000_0000_8000_0000;
   // ----------------------------------------------------------------
   // ID register fields
   // ----------------------------------------------------------------
   localparam int PIDV_ID_SDEF_BIT = 61;
   localparam int PIDV_ID_FNS_BIT = 60;
   localparam int PIDV_ID_TRAP_SUP_BIT = 58;
   localparam int PIDV_ID_MON_GROUP_LSB = 32;
   localparam int PIDV_ID_VPMR_LSB = 18;
   localparam int PIDV_ID_VIRT_BIT = 17;
   localparam logic [11:0] PIDV_REDIR_HCR_OFFS = 12'h930;
   localparam logic [11:0] PIDV_REDIR_NONE = 12'h000;
   localparam logic [5:0] PIDV_EC_SYSREG = 6'h18;
   localparam logic [5:0] PIDV_EC_NONE = 6'h00;
   localparam logic [15:0] PIDV_DEFAULT_PID = 16'h0000;
   localparam int PIDV_PID_W = 16;
   localparam int PIDV_MAP_ENTRIES = 4;
   // Exception levels
   typedef enum logic [1:0] {PIDV_EL0, PIDV_EL1, PIDV_EL2, PIDV_EL3} pidv_el_e;
   // Access outcome
   typedef enum logic [1:0] {PIDV_OK, PIDV_UNDEF, PIDV_TRAP, PIDV_REDIR} pidv_res_e;
endpackage

// ---- pidv_map_if.sv ----
// Interface: virtual partition ID lookup between label path and mapper
`timescale 1ns/1ps
interface pidv_map_if;
   logic [15:0] vpid_i;
   logic [15:0] vpid_d;
   logic [15:0] ppid_i;
   logic [15:0] ppid_d;
   logic hit_i;
   logic hit_d;
   modport req (output vpid_i, output vpid_d, input ppid_i, input ppid_d, input hit_i,
      input hit_d);
   modport map (input vpid_i, input vpid_d, output ppid_i, output ppid_d, output hit_i,
      output hit_d);
endinterface

// ---- pidv_mapper.sv ----
// Mapper: virtual-to-physical partition ID lookup
`timescale 1ns/1ps
module pidv_mapper
   import pidv_pkg::*;
(
   input wire logic [63:0] map_reg_i,
   input wire logic [3:0] map_valid_i,
   pidv_map_if.map mif
);
   logic [15:0] ent [PIDV_MAP_ENTRIES];
   // ----------------------------------------------------------------
   // Entry slicing, lowest virtual ID in low bits
   // ----------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < PIDV_MAP_ENTRIES; g++)
      begin : g_ent
         assign ent[g] = map_reg_i[g*PIDV_PID_W +: PIDV_PID_W];
      end
   endgenerate
   // Only one mapping register held here; higher IDs miss
   assign mif.hit_i = (mif.vpid_i < 16'(PIDV_MAP_ENTRIES)) && map_valid_i[mif.vpid_i[1:0]];
   assign mif.hit_d = (mif.vpid_d < 16'(PIDV_MAP_ENTRIES)) && map_valid_i[mif.vpid_d[1:0]];
   assign mif.ppid_i = ent[mif.vpid_i[1:0]];
   assign mif.ppid_d = ent[mif.vpid_d[1:0]];
endmodule

// ---- pidv_ctrl_monitor.sv ----
// Checker: access outcome and label timing of the partition-ID control block
`timescale 1ns/1ps
module pidv_ctrl_monitor
   import pidv_pkg::*;
#(
   parameter bit HAS_EL3 = 1'b0
)
(
   input wire logic mclk_i,
   input wire logic reset_n_i,
   input wire logic acc_valid_i,
   input wire logic acc_write_i,
   input wire logic [1:0] acc_op0_i,
   input wire logic [2:0] acc_op1_i,
   input wire logic [3:0] acc_crn_i,
   input wire logic [3:0] acc_crm_i,
   input wire logic [2:0] acc_op2_i,
   input wire logic [1:0] cur_el_i,
   input wire logic el2_enabled_i,
   input wire logic secure_i,
   input wire logic halted_i,
   input wire logic nested_virt_i,
   input wire logic nested_virt_memory_i,
   input wire logic lower_level_trap_i,
   input wire logic secure_default_override_i,
   input wire logic acc_done_o,
   input wire logic [1:0] acc_result_o,
   input wire logic [1:0] acc_trap_el_o,
   input wire logic [5:0] acc_syndrome_o,
   input wire logic [11:0] acc_redir_offs_o,
   input wire logic [63:0] acc_rdata_o,
   input wire logic [15:0] instruction_partition_id_o,
   input wire logic [15:0] data_partition_id_o
);
   wire logic hcr_enc;
   assign hcr_enc = acc_op0_i == PIDV_OP0 && acc_op1_i == PIDV_HCR_OP1 && acc_crn_i == PIDV_CRN
      && acc_crm_i == PIDV_HCR_CRM && acc_op2_i == PIDV_HCR_OP2;
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!reset_n_i);
   done_pulse_a: assert property (acc_done_o == $past(acc_valid_i))
      else $error("done not one cycle after request");
   el0_undef_a: assert property (acc_valid_i && cur_el_i == 2'h0 |=> acc_result_o == 2'h1)
      else $error("level 0 access not undefined");
   el3_ctrl_ok_a: assert property (acc_valid_i && hcr_enc && cur_el_i == 2'h3
      |=> acc_done_o && acc_result_o == 2'h0) else $error("level 3 control access refused");
   mem_redir_a: assert property (acc_valid_i && hcr_enc && cur_el_i == 2'h1 && el2_enabled_i
      && nested_virt_i && nested_virt_memory_i |=> acc_result_o == 2'h3
      && acc_redir_offs_o == 12'h930) else $error("redirect missing");
   trap_syndrome_a: assert property (acc_done_o && acc_result_o == 2'h2
      |-> acc_syndrome_o == 6'h18 && acc_trap_el_o[1]) else $error("bad trap syndrome");
   lower_trap_a: assert property (HAS_EL3 && acc_valid_i && hcr_enc && cur_el_i == 2'h2
      && lower_level_trap_i && !halted_i |=> acc_result_o == 2'h2 && acc_trap_el_o == 2'h3)
      else $error("lower-level trap missing");
   ctrl_reserved_a: assert property (acc_valid_i && hcr_enc && !acc_write_i
      && cur_el_i == 2'h3 |=> (acc_rdata_o & ~PIDV_HCR_WMASK) == 64'h0)
      else $error("reserved control bits set");
   sdef_zero_a: assert property (secure_i && secure_default_override_i && !cur_el_i[1]
      |=> instruction_partition_id_o == 16'h0 && data_partition_id_o == 16'h0)
      else $error("secure default id not zero");
endmodule
bind pidv_ctrl pidv_ctrl_monitor #(.HAS_EL3(HAS_EL3)) i_pidv_ctrl_monitor (.*);

// ---- pidv_ctrl_tb.sv ----
// Testbench: directed and random access and label checks of the control block
`timescale 1ns/1ps
module pidv_ctrl_tb;
   import pidv_pkg::*;
   localparam logic [63:0] ID_EXP = 64'h3400_003c_0002_01f7;
   logic mclk_i, reset_n_i, acc_valid_i, acc_write_i, el2_enabled_i, secure_i, halted_i;
   logic secure_debug_disable_i, trap_general_i, host_extension_i, nested_virt_i;
   logic nested_virt_memory_i, lower_level_trap_i, hyp_id_trap_bit_i, ev, elab;
   logic secure_default_override_i, force_nonsecure_i, acc_done_o, nonsecure_label_bit_o;
   logic [1:0] acc_op0_i, cur_el_i, acc_result_o, acc_trap_el_o;
   logic [2:0] acc_op1_i, acc_op2_i;
   logic [3:0] acc_crn_i, acc_crm_i, map_valid_register_i, er;
   logic [5:0] acc_syndrome_o;
   logic [11:0] acc_redir_offs_o;
   logic [15:0] instruction_partition_id_o, data_partition_id_o;
   logic [31:0] level0_label_register_i, level1_label_register_i;
   logic [32:0] elv;
   logic [63:0] acc_wdata_i, virtual_map_register_i, acc_rdata_o, hcr, erd;
   int error_cnt = 0, num_checks = 0, seed = 32'hcef7, cyc = 0;
   pidv_ctrl #(.HAS_EL3(1'b1), .MAX_MON_GROUP(8'h3c), .MAX_VPMR(3'h0), .MAX_PID(16'h01f7))
      i_pidv_ctrl (.*);
   initial
   begin
      mclk_i = 1'b0;
      forever #2.5 mclk_i = ~mclk_i;
   end
   always @(posedge mclk_i)
   begin
      cyc++;
      if (cyc == 10000)
      begin
         error_cnt++;
         conclude();
      end
   end
   task automatic conclude();
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // -------------------------------
   // Reference model
   // -------------------------------
   function automatic logic [15:0] vmap(input logic [15:0] v);
      // Only map register 0 exists, so higher virtual ids give zero
      return (v < 16'h0004 && map_valid_register_i[v[1:0]]) ?
         virtual_map_register_i[16*v[1:0] +: 16] : 16'h0000;
   endfunction
   function automatic logic [31:0] label();
      logic [31:0] src;
      logic mp;
      if (cur_el_i == 2'h0 && !(el2_enabled_i && !trap_general_i && hcr[8]))
      begin
         src = level0_label_register_i;
         mp = hcr[0] && !(host_extension_i && trap_general_i);
      end
      else
      begin
         src = level1_label_register_i;
         mp = hcr[1];
      end
      if (secure_i && secure_default_override_i)
         return 32'h0000_0000;
      if (mp && el2_enabled_i)
         return {vmap(src[31:16]), vmap(src[15:0])};
      return src;
   endfunction
   function automatic logic [3:0] decide();
      logic [15:0] e;
      logic h, i;
      e = {acc_op0_i, acc_op1_i, acc_crn_i, acc_crm_i, acc_op2_i};
      h = e == 16'he520;
      i = e == 16'hc524 && !acc_write_i;
      if (!(h || i) || cur_el_i == 2'h0)
         return 4'h1;
      if (cur_el_i == 2'h3)
         return 4'h0;
      if (h && cur_el_i == 2'h1 && !(el2_enabled_i && nested_virt_i))
         return 4'h1;
      if (h && cur_el_i == 2'h1 && nested_virt_memory_i)
         return 4'h3;
      if (lower_level_trap_i)
         return (halted_i && secure_debug_disable_i) ? 4'h1 : 4'he;
      if (h && cur_el_i == 2'h1)
         return 4'ha;
      if (i && cur_el_i == 2'h1 && el2_enabled_i && (hcr[31] || hyp_id_trap_bit_i))
         return 4'ha;
      return 4'h0;
   endfunction
   // -------------------------------
   // Stimulus
   // -------------------------------
   task automatic drive(input int mode);
      logic [31:0] x, y, z;
      x = $random(seed);
      y = $random(seed);
      z = $random(seed);
      acc_valid_i = x[0] | x[1];
      acc_write_i = x[2];
      {acc_op0_i, acc_op1_i, acc_crn_i, acc_crm_i, acc_op2_i} =
         (x[4:3] == 2'h0) ? 16'hc524 : (x[4:3] == 2'h1) ? y[15:0] : 16'he520;
      cur_el_i = x[6:5];
      el2_enabled_i = x[7] | x[8];
      secure_i = x[9];
      halted_i = x[10];
      secure_debug_disable_i = x[11];
      trap_general_i = x[12];
      host_extension_i = x[13];
      nested_virt_i = x[14] | x[15];
      nested_virt_memory_i = x[16];
      lower_level_trap_i = x[17] & x[18];
      hyp_id_trap_bit_i = x[19];
      secure_default_override_i = x[20] & x[21];
      force_nonsecure_i = x[22];
      map_valid_register_i = x[26:23];
      acc_wdata_i = {y, z};
      virtual_map_register_i = {z, y};
      // Small ids half the time so map entries are reached
      level0_label_register_i = x[27] ? z & 32'h0003_0003 : z;
      level1_label_register_i = x[28] ? y & 32'h0007_0003 : y;
      if (mode != 0)
      begin
         acc_valid_i = 1'b1;
         acc_write_i = 1'b0;
         cur_el_i = 2'h3;
         {acc_op0_i, acc_op1_i, acc_crn_i, acc_crm_i, acc_op2_i} =
            (mode == 1) ? 16'he520 : 16'hc524;
      end
      ev = acc_valid_i;
      er = decide();
      erd = (er[1:0] == 2'h0 && !acc_write_i) ? (acc_op2_i == 3'h0 ? hcr : ID_EXP) : 64'h0;
      elab = !cur_el_i[1];
      elv = {label(), !secure_i || force_nonsecure_i};
      if (ev && acc_write_i && er[1:0] == 2'h0)
         hcr = acc_wdata_i & 64'h0000_0000_8000_0103;
      @(negedge mclk_i);
   endtask
   task automatic step(input int mode);
      chk(64'(acc_done_o), 64'(ev));
      if (ev)
      begin
         chk(64'(acc_result_o), 64'(er[1:0]));
         chk(acc_rdata_o, erd);
         if (er[1:0] == 2'h2)
            chk(64'({acc_trap_el_o, acc_syndrome_o}), 64'({er[3:2], 6'h18}));
         if (er[1:0] == 2'h3)
            chk(64'(acc_redir_offs_o), 64'h0000_0000_0000_0930);
      end
      if (elab)
         chk(64'({data_partition_id_o, instruction_partition_id_o, nonsecure_label_bit_o}),
            64'(elv));
      drive(mode);
   endtask
   task automatic rst();
      reset_n_i = 1'b0;
      acc_valid_i = 1'b0;
      repeat (8) @(negedge mclk_i);
      chk(64'({acc_done_o, nonsecure_label_bit_o}), 64'h0000_0000_0000_0001);
      reset_n_i = 1'b1;
      hcr = 64'h0000_0000_8000_0000;
      ev = 1'b0;
      elab = 1'b0;
   endtask
   initial
   begin
      reset_n_i = 1'b0;
      drive(0);
      for (int t = 0; t < 2; t++)
      begin
         rst();
         step(1);
         step(2);
         repeat (2000) step(0);
         $display("random run %0d done, %0d checks", t, num_checks);
      end
      conclude();
   end
endmodule
